//--- verilog/gpc_cfg.svh
// Offsets, field positions, reset values and limits of the counter pair
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define OFS_FIRST_RAW        6'h00
`define OFS_FIRST_VALUE      6'h04
`define OFS_FIRST_SETPOINT   6'h08
`define OFS_FIRST_MAXIMUM    6'h0c
`define OFS_GEAR_NUMERATOR   6'h10
`define OFS_GEAR_DENOMINATOR 6'h14
`define OFS_FIRST_CONTROL    6'h18
`define OFS_SECOND_ACTUAL    6'h1c
`define OFS_SECOND_SETPOINT  6'h20
`define OFS_SECOND_MAXIMUM   6'h24
`define OFS_SECOND_CONTROL   6'h28
`define OFS_IRQ_STATUS       6'h2c
`define OFS_IRQ_MASK         6'h30
`define OFS_LIVE_STATUS      6'h34

// ==========================================================================
// Reset values
`define RST_FIRST_SETPOINT   32'h0000_03e8
`define RST_FIRST_MAXIMUM    32'hffff_ffff
`define RST_GEAR_TERM        16'h0001
`define RST_FIRST_CONTROL    16'h0001
`define RST_SECOND_SETPOINT  16'h03e8
`define RST_SECOND_MAXIMUM   16'hffff
`define RST_SECOND_CONTROL   16'h0064

// ==========================================================================
// Control setting decimal digits
`define CTRL_HUNDRED         8'h64
`define CTRL_TEN             8'h0a
`define CTRL_LIMIT           16'h0083
`define CTRL_MAX_TENS        2'h3

// ==========================================================================
// Interrupt status / live status bit positions
`define IRQ_FIRST_REACHED    0
`define IRQ_SECOND_REACHED   1
`define IRQ_FIRST_AT_MAX     2
`define IRQ_SECOND_AT_MAX    3
`define IRQ_WIDTH            4

`endif

//--- verilog/gpc_pkg.sv
// Types shared by the counter pair
package gpc_pkg;

  typedef enum logic [1:0] {
    STOP_CONTINUE,
    STOP_COAST,
    STOP_RAMP,
    STOP_EMERGENCY
  } stop_action_e;

  typedef enum logic {
    METHOD_HOLD,
    METHOD_WRAP
  } count_method_e;

  typedef struct packed {
    logic          retain;
    stop_action_e  action;
    count_method_e method;
  } ctrl_digits_s;

  typedef struct packed {
    logic         active;
    stop_action_e kind;
  } stop_req_s;

endpackage

//--- verilog/pulse_counter_core.sv
// One up counter with maximum handling, clear and set value compare
module pulse_counter_core #(
  parameter int W = 32
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   step,
  input  wire logic                   clear,
  input  wire gpc_pkg::count_method_e method,
  input  wire logic [W-1:0]           maximum,
  input  wire logic [W-1:0]           setpoint,
  output logic      [W-1:0]           count,
  output logic                        reached,
  output logic                        at_max
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // ========================================================================
  // Next count
  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (step) begin
      if (count_reg >= maximum) begin
        if (method == gpc_pkg::METHOD_WRAP) begin
          count_next = '0;
        end
      end else begin
        count_next = count_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign reached = (count_reg >= setpoint);
  assign at_max  = (count_reg >= maximum);

endmodule

//--- verilog/geared_pulse_counter_pair.sv
// Geared 32-bit and plain 16-bit pulse counters with Avalon-MM registers
`include "gpc_cfg.svh"

module geared_pulse_counter_pair (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Terminals
  input  wire logic                first_pulse_in,
  input  wire logic                first_clear_in,
  input  wire logic                second_pulse_in,
  input  wire logic                second_clear_in,
  output logic                     first_reached_out,
  output logic                     second_reached_out,
  output gpc_pkg::stop_req_s       first_stop_req,
  output gpc_pkg::stop_req_s       second_stop_req,
  output logic                     first_retain,
  output logic                     second_retain,
  output logic                     irq
);

  // ========================================================================
  // Helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Control setting is a decimal number: hundreds, tens, units digits
  function automatic gpc_pkg::ctrl_digits_s decode_ctrl(input logic [15:0] v);
    gpc_pkg::ctrl_digits_s d;
    logic [7:0]            rem;
    logic [1:0]            tens;
    rem  = (v[7:0] >= `CTRL_HUNDRED) ? v[7:0] - `CTRL_HUNDRED : v[7:0];
    tens = (rem >= 8'(3 * `CTRL_TEN)) ? 2'h3 :
           (rem >= 8'(2 * `CTRL_TEN)) ? 2'h2 :
           (rem >= `CTRL_TEN)         ? 2'h1 : 2'h0;
    rem  = rem - 8'(tens * `CTRL_TEN);
    d.retain = (v[7:0] >= `CTRL_HUNDRED);
    d.action = gpc_pkg::stop_action_e'(tens);
    d.method = gpc_pkg::count_method_e'(rem[0]);
    return d;
  endfunction

  // Legal when the decoded digits give back the same value
  function automatic logic ctrl_legal(input logic [15:0] v);
    gpc_pkg::ctrl_digits_s d;
    d = decode_ctrl(v);
    return (v <= `CTRL_LIMIT) &&
           (v[7:0] == (d.retain ? `CTRL_HUNDRED : 8'h00) + 8'(d.action) * `CTRL_TEN
                      + 8'(d.method));
  endfunction

  // ========================================================================
  // Register state
  logic [31:0] first_setpoint_reg,   first_setpoint_next;
  logic [31:0] first_maximum_reg,    first_maximum_next;
  logic [15:0] gear_numerator_reg,   gear_numerator_next;
  logic [15:0] gear_denominator_reg, gear_denominator_next;
  logic [15:0] first_control_reg,    first_control_next;
  logic [15:0] second_setpoint_reg,  second_setpoint_next;
  logic [15:0] second_maximum_reg,   second_maximum_next;
  logic [15:0] second_control_reg,   second_control_next;
  logic [`IRQ_WIDTH-1:0] irq_status_reg, irq_status_next;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg,   irq_mask_next;
  logic        ack_reg,     ack_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [31:0] first_raw_reg, first_raw_next;

  logic [31:0] first_count;
  logic [15:0] second_count;
  logic        first_reached,  second_reached;
  logic        first_at_max,   second_at_max;
  logic [`IRQ_WIDTH-1:0] live;
  logic [`IRQ_WIDTH-1:0] live_prev_reg;
  logic [31:0] wval,        rsel;
  logic        wr_take;

  gpc_pkg::ctrl_digits_s first_ctrl, second_ctrl;

  assign first_ctrl  = decode_ctrl(first_control_reg);
  assign second_ctrl = decode_ctrl(second_control_reg);

  // ========================================================================
  // Bus handshake: one wait cycle on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_take         = avs_write & ack_reg;
  assign avs_readdata    = rdata_reg;

  always_comb begin
    first_setpoint_next   = first_setpoint_reg;
    first_maximum_next    = first_maximum_reg;
    gear_numerator_next   = gear_numerator_reg;
    gear_denominator_next = gear_denominator_reg;
    first_control_next    = first_control_reg;
    second_setpoint_next  = second_setpoint_reg;
    second_maximum_next   = second_maximum_reg;
    second_control_next   = second_control_reg;
    irq_mask_next         = irq_mask_reg;
    ack_next              = (avs_read | avs_write) & ~ack_reg;
    rdata_next            = rdata_reg;
    irq_status_next       = irq_status_reg;
    // Current value of the addressed register, for reads and lane merges
    unique case (avs_address)
      `OFS_FIRST_RAW:        rsel = first_raw_reg;
      `OFS_FIRST_VALUE:      rsel = first_count;
      `OFS_FIRST_SETPOINT:   rsel = first_setpoint_reg;
      `OFS_FIRST_MAXIMUM:    rsel = first_maximum_reg;
      `OFS_GEAR_NUMERATOR:   rsel = {16'h0000, gear_numerator_reg};
      `OFS_GEAR_DENOMINATOR: rsel = {16'h0000, gear_denominator_reg};
      `OFS_FIRST_CONTROL:    rsel = {16'h0000, first_control_reg};
      `OFS_SECOND_ACTUAL:    rsel = {16'h0000, second_count};
      `OFS_SECOND_SETPOINT:  rsel = {16'h0000, second_setpoint_reg};
      `OFS_SECOND_MAXIMUM:   rsel = {16'h0000, second_maximum_reg};
      `OFS_SECOND_CONTROL:   rsel = {16'h0000, second_control_reg};
      `OFS_IRQ_STATUS:       rsel = {28'h000_0000, irq_status_reg};
      `OFS_IRQ_MASK:         rsel = {28'h000_0000, irq_mask_reg};
      `OFS_LIVE_STATUS:      rsel = {28'h000_0000, live};
      default:               rsel = 32'h0000_0000;
    endcase
    wval = merge_bytes(rsel, avs_writedata, avs_byteenable);
    if (wr_take) begin
      unique case (avs_address)
        `OFS_FIRST_SETPOINT:   if (wval != 32'h0000_0000) first_setpoint_next = wval;
        `OFS_FIRST_MAXIMUM:    if (wval != 32'h0000_0000) first_maximum_next = wval;
        `OFS_GEAR_NUMERATOR:   if (wval[15:0] != 16'h0000) gear_numerator_next = wval[15:0];
        `OFS_GEAR_DENOMINATOR: if (wval[15:0] != 16'h0000) gear_denominator_next = wval[15:0];
        `OFS_FIRST_CONTROL:    if (ctrl_legal(wval[15:0])) first_control_next = wval[15:0];
        `OFS_SECOND_SETPOINT:  if (wval[15:0] != 16'h0000) second_setpoint_next = wval[15:0];
        `OFS_SECOND_MAXIMUM:   if (wval[15:0] != 16'h0000) second_maximum_next = wval[15:0];
        `OFS_SECOND_CONTROL:   if (ctrl_legal(wval[15:0])) second_control_next = wval[15:0];
        `OFS_IRQ_STATUS:       if (avs_byteenable[0])
                                 irq_status_next = irq_status_reg & ~avs_writedata[`IRQ_WIDTH-1:0];
        `OFS_IRQ_MASK:         irq_mask_next = wval[`IRQ_WIDTH-1:0];
        default:               ;
      endcase
    end
    // Set wins over a clear in the same cycle
    irq_status_next = irq_status_next | (live & ~live_prev_reg);
    if (avs_read && !ack_reg) begin
      rdata_next = rsel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_setpoint_reg   <= `RST_FIRST_SETPOINT;
      first_maximum_reg    <= `RST_FIRST_MAXIMUM;
      gear_numerator_reg   <= `RST_GEAR_TERM;
      gear_denominator_reg <= `RST_GEAR_TERM;
      first_control_reg    <= `RST_FIRST_CONTROL;
      second_setpoint_reg  <= `RST_SECOND_SETPOINT;
      second_maximum_reg   <= `RST_SECOND_MAXIMUM;
      second_control_reg   <= `RST_SECOND_CONTROL;
      irq_status_reg       <= '0;
      irq_mask_reg         <= '0;
      ack_reg              <= 1'b0;
      rdata_reg            <= 32'h0000_0000;
    end else begin
      first_setpoint_reg   <= first_setpoint_next;
      first_maximum_reg    <= first_maximum_next;
      gear_numerator_reg   <= gear_numerator_next;
      gear_denominator_reg <= gear_denominator_next;
      first_control_reg    <= first_control_next;
      second_setpoint_reg  <= second_setpoint_next;
      second_maximum_reg   <= second_maximum_next;
      second_control_reg   <= second_control_next;
      irq_status_reg       <= irq_status_next;
      irq_mask_reg         <= irq_mask_next;
      ack_reg              <= ack_next;
      rdata_reg            <= rdata_next;
    end
  end

  // ========================================================================
  // Pulse edges and gear stage
  logic        first_pulse_prev_reg,  second_pulse_prev_reg;
  logic        first_edge,            second_edge;
  logic [31:0] residue_reg,           residue_next;
  logic        gear_step;

  assign first_edge  = first_pulse_in  & ~first_pulse_prev_reg;
  assign second_edge = second_pulse_in & ~second_pulse_prev_reg;
  assign gear_step   = (residue_reg >= {16'h0000, gear_denominator_reg});

  always_comb begin
    first_raw_next = first_raw_reg;
    residue_next   = residue_reg;
    if (first_clear_in) begin
      first_raw_next = 32'h0000_0000;
      residue_next   = 32'h0000_0000;
    end else begin
      if (first_edge) begin
        first_raw_next = first_raw_reg + 32'h0000_0001;
      end
      residue_next = residue_reg
                     + (first_edge ? {16'h0000, gear_numerator_reg} : 32'h0000_0000)
                     - (gear_step ? {16'h0000, gear_denominator_reg} : 32'h0000_0000);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_pulse_prev_reg  <= 1'b0;
      second_pulse_prev_reg <= 1'b0;
      first_raw_reg         <= 32'h0000_0000;
      residue_reg           <= 32'h0000_0000;
      live_prev_reg         <= '0;
    end else begin
      first_pulse_prev_reg  <= first_pulse_in;
      second_pulse_prev_reg <= second_pulse_in;
      first_raw_reg         <= first_raw_next;
      residue_reg           <= residue_next;
      live_prev_reg         <= live;
    end
  end

  // ========================================================================
  // Counters
  // geared 32-bit counter
  pulse_counter_core #(.W(32)) u_first (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .step     (gear_step),
    .clear    (first_clear_in),
    .method   (first_ctrl.method),
    .maximum  (first_maximum_reg),
    .setpoint (first_setpoint_reg),
    .count    (first_count),
    .reached  (first_reached),
    .at_max   (first_at_max)
  );

  pulse_counter_core #(.W(16)) u_second (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .step     (second_edge),
    .clear    (second_clear_in),
    .method   (second_ctrl.method),
    .maximum  (second_maximum_reg),
    .setpoint (second_setpoint_reg),
    .count    (second_count),
    .reached  (second_reached),
    .at_max   (second_at_max)
  );

  always_comb begin
    live = '0;
    live[`IRQ_FIRST_REACHED]  = first_reached;
    live[`IRQ_SECOND_REACHED] = second_reached;
    live[`IRQ_FIRST_AT_MAX]   = first_at_max;
    live[`IRQ_SECOND_AT_MAX]  = second_at_max;
  end

  // ========================================================================
  // Outputs
  gpc_pkg::stop_req_s first_stop_reg,  first_stop_next;
  gpc_pkg::stop_req_s second_stop_reg, second_stop_next;
  logic               first_reached_reg, second_reached_reg;
  logic               first_retain_reg,  second_retain_reg;

  always_comb begin
    first_stop_next.active  = first_reached &
                              (first_ctrl.action != gpc_pkg::STOP_CONTINUE);
    first_stop_next.kind    = first_ctrl.action;
    second_stop_next.active = second_reached &
                              (second_ctrl.action != gpc_pkg::STOP_CONTINUE);
    second_stop_next.kind   = second_ctrl.action;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      first_stop_reg     <= '0;
      second_stop_reg    <= '0;
      first_reached_reg  <= 1'b0;
      second_reached_reg <= 1'b0;
      first_retain_reg   <= 1'b0;
      second_retain_reg  <= 1'b0;
    end else begin
      first_stop_reg     <= first_stop_next;
      second_stop_reg    <= second_stop_next;
      first_reached_reg  <= first_reached;
      second_reached_reg <= second_reached;
      first_retain_reg   <= first_ctrl.retain;
      second_retain_reg  <= second_ctrl.retain;
    end
  end

  assign first_stop_req     = first_stop_reg;
  assign second_stop_req    = second_stop_reg;
  assign first_reached_out  = first_reached_reg;
  assign second_reached_out = second_reached_reg;
  assign first_retain       = first_retain_reg;
  assign second_retain      = second_retain_reg;
  assign irq                = |(irq_status_reg & irq_mask_reg);

endmodule

//--- verif/gpc_sva.sv
// Port checks for the geared counter pair
module gpc_sva (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic               first_clear_in,
  input wire logic               second_clear_in,
  input wire logic               first_reached_out,
  input wire logic               second_reached_out,
  input wire gpc_pkg::stop_req_s first_stop_req,
  input wire gpc_pkg::stop_req_s second_stop_req,
  input wire logic               first_retain
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence clr1_s; first_clear_in [*2]; endsequence
  sequence clr2_s; second_clear_in [*2]; endsequence
  // ==========================================================
  // Bus, clear, stop request and retain relations
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  clear_first_a: assert property (clr1_s |=> !first_reached_out)
    else $error("first counter not cleared");
  clear_second_a: assert property (clr2_s |=> !second_reached_out)
    else $error("second counter not cleared");
  stop_first_a: assert property (first_stop_req.active |-> first_reached_out ||
    $past(first_reached_out)) else $error("first stop without reach");
  stop_second_a: assert property (second_stop_req.active |-> second_reached_out ||
    $past(second_reached_out)) else $error("second stop without reach");
  kind_first_a: assert property (first_stop_req.active |->
    first_stop_req.kind != gpc_pkg::STOP_CONTINUE) else $error("first stop kind");
  kind_second_a: assert property (second_stop_req.active |->
    second_stop_req.kind != gpc_pkg::STOP_CONTINUE) else $error("second stop kind");
  retain_hold_a: assert property ($changed(first_retain) |-> $past(avs_write) ||
    $past(avs_write, 2)) else $error("retain changed without write");
endmodule

//--- verif/pulse_source.sv
// Pulse terminal and clear terminal model
module pulse_source (
  input wire logic  clk_sys,
  input wire logic  reset_n,
  input wire logic  go,
  input wire logic  sel,
  input wire logic  [7:0] n,
  input wire logic  clr_a,
  input wire logic  clr_b,
  output logic      pulse_a,
  output logic      pulse_b,
  output logic      clear_a,
  output logic      clear_b,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [2:0] ph;
  logic       sel_r;
  // ==========================================================
  // Burst of pulses, high 1 cycle, low 4
  always_ff @(posedge clk_sys) begin
    clear_a <= reset_n && clr_a;
    clear_b <= reset_n && clr_b;
    if (!reset_n) begin
      left <= 8'h00;
      ph <= 3'h0;
    end else if (go) begin
      left <= n;
      ph <= 3'h0;
      sel_r <= sel;
    end else if (left != 8'h00) begin
      ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h4) left <= left - 8'h01;
    end
  end
  assign busy = left != 8'h00;
  assign pulse_a = busy && ph == 3'h0 && !sel_r;
  assign pulse_b = busy && ph == 3'h0 && sel_r;
endmodule

//--- verif/testbench.sv
// Self-checking bench for the geared counter pair
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, avs_read, avs_write, go, sel, clr_a, clr_b;
  logic p1, p2, c1, c2, busy, r1, r2, rt1, rt2, irq, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, exp_v, seed;
  logic [7:0] cnt;
  logic [2:0] e;
  gpc_pkg::stop_req_s s1, s2;
  logic [31:0] exp_q [$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic [5:0] ofs [10] = '{6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24, 6'h28, 6'h2c, 6'h3c};
  logic [31:0] rst [10] = '{32'h3e8, 32'hffffffff, 32'h1, 32'h1, 32'h1, 32'h3e8, 32'hffff,
                            32'h64, 32'h0, 32'h0};
  geared_pulse_counter_pair uut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_pulse_in(p1), .first_clear_in(c1), .second_pulse_in(p2), .second_clear_in(c2),
    .first_reached_out(r1), .second_reached_out(r2), .first_stop_req(s1), .second_stop_req(s2),
    .first_retain(rt1), .second_retain(rt2), .irq(irq));
  pulse_source src (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .sel(sel), .n(cnt),
    .clr_a(clr_a), .clr_b(clr_b), .pulse_a(p1), .pulse_b(p2), .clear_a(c1), .clear_b(c2),
    .busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Avalon master and pulse tasks
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pulses(input logic s, input logic [7:0] n);
    go <= 1'b1;
    sel <= s;
    cnt <= n;
    @(posedge clk_sys);
    go <= 1'b0;
    do @(posedge clk_sys); while (busy);
    repeat (6) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) if (avs_read && !avs_waitrequest) begin
    exp_v = exp_q.pop_front();
    `CHK(avs_readdata, exp_v)
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Main sequence
  initial begin
    {reset_n, avs_read, avs_write, go, sel, clr_a, clr_b} = 7'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    cnt = 8'h00;
    seed = 32'h1c8f;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) rd(ofs[i], rst[i]);
    `CHK(rt2, 1'b1)
    bus(1'b1, 6'h20, 32'h0);
    rd(6'h20, 32'h3e8);
    bus(1'b1, 6'h10, 32'h3);
    bus(1'b1, 6'h08, 32'h3);
    bus(1'b1, 6'h0c, 32'd20);
    pulses(1'b0, 8'd8);
    rd(6'h00, 32'd8);
    rd(6'h04, 32'd3);
    `CHK(r1, 1'b1)
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 6'h18, 32'(k * 10 + 1));
      repeat (2) @(posedge clk_sys);
      e = {k != 0, 2'(k)};
      `CHK(s1, e)
    end
    bus(1'b1, 6'h18, 32'd101);
    bus(1'b1, 6'h18, 32'd132);
    rd(6'h18, 32'd101);
    `CHK(rt1, 1'b1)
    clr_a <= 1'b1;
    pulses(1'b0, 8'd2);
    clr_a <= 1'b0;
    rd(6'h04, 32'h0);
    bus(1'b1, 6'h2c, 32'hf);
    bus(1'b1, 6'h30, 32'h1);
    `CHK(irq, 1'b0)
    pulses(1'b0, 8'd1);
    `CHK(irq, 1'b1)
    bus(1'b1, 6'h30, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, 6'h30, 32'h1);
    bus(1'b1, 6'h2c, 32'h1);
    `CHK(irq, 1'b0)
    bus(1'b1, 6'h24, 32'd5);
    bus(1'b1, 6'h20, 32'd4);
    pulses(1'b1, 8'd8);
    rd(6'h1c, 32'd5);
    `CHK(r2, 1'b1)
    bus(1'b1, 6'h1c, 32'h9);
    rd(6'h1c, 32'd5);
    bus(1'b1, 6'h28, 32'd30);
    repeat (2) @(posedge clk_sys);
    `CHK(s2, 3'h7)
    for (int j = 0; j < 3; j++) begin
      seed = lfsr(seed);
      clr_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      clr_b <= 1'b0;
      @(posedge clk_sys);
      pulses(1'b1, {6'h0, seed[1:0]} + 8'd1);
      rd(6'h1c, {30'h0, seed[1:0]} + 32'd1);
    end
    test_done;
  end
endmodule
bind geared_pulse_counter_pair gpc_sva chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .first_clear_in(first_clear_in), .second_clear_in(second_clear_in),
  .first_reached_out(first_reached_out), .second_reached_out(second_reached_out),
  .first_stop_req(first_stop_req), .second_stop_req(second_stop_req),
  .first_retain(first_retain));
